// ---- verilog/hub_cfg_pkg.sv ----
// Notes on behaviour
// - Index 3 with nonzero maker length returns maker text bytes.
// - Maker bytes returned equal the maker text length.
// - Index 2 with nonzero item length returns item text bytes.
// - Item bytes returned equal the item text length.
// - Bits 3:1 set switch-on delay in 200 ms steps.
// - Feature bit 0 high turns PLL spread spectrum off.
// - Feature fields take loader values and later host overwrites.
// - Flag set on config mode entry; blocks upstream; host clears by one.
// - Host reset bit restores all registers, sets flag, self-clears.
package hub_cfg_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] MAKER_TEXT_BASE = 8'h50;
	localparam logic [7:0] ITEM_TEXT_BASE = 8'h90;
	localparam logic [7:0] TEXT_END = 8'hCF;
	localparam int TEXT_BYTES = 64;
	localparam int TEXT_TOTAL = 128;
	localparam logic [7:0] FEATURE_CFG_ADDR = 8'hF0;
	localparam logic [7:0] HOST_STATUS_ADDR = 8'hF8;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ==========================================================
	// Fields
	localparam int LINK_PINS_EN_BIT = 4;
	localparam int DELAY_SEL_LSB = 1;
	localparam int DELAY_SEL_MSB = 3;
	localparam int SPREAD_OFF_BIT = 0;
	localparam int CFG_ACTIVE_BIT = 0;
	localparam int HOST_RESET_BIT = 1;
	// ==========================================================
	// Descriptor indices
	localparam logic [7:0] DESC_INDEX_MAKER = 8'h03;
	localparam logic [7:0] DESC_INDEX_ITEM = 8'h02;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int DELAY_STEP_MS = 200;
	localparam int DELAY_STEP_CYCLES = DELAY_STEP_MS * 1000 * CLK_MHZ;
endpackage

// ---- verilog/switch_on_timer.sv ----
module switch_on_timer #(
	parameter int STEP_CYCLES = 20000000
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic request,
	input wire logic [2:0] delay_sel,
	output logic switch_enable
);
	localparam int CW = $clog2(STEP_CYCLES) + 1;
	localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);
	logic request_d;
	logic running;
	logic [CW-1:0] cycle_count;
	logic [2:0] steps_left;
	logic [31:0] waited;
	logic [2:0] delay_taken;

	// ==========================================================
	// Delay counter: (delay_sel + 1) steps from request rise
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			request_d <= 1'b0;
			running <= 1'b0;
			cycle_count <= '0;
			steps_left <= 3'h0;
			switch_enable <= 1'b0;
		end else begin
			request_d <= request;
			if (!request) begin
				running <= 1'b0;
				switch_enable <= 1'b0;
				cycle_count <= '0;
			end else if (!request_d) begin
				running <= 1'b1;
				steps_left <= delay_sel;
				cycle_count <= '0;
			end else if (running) begin
				if (cycle_count == LAST) begin
					cycle_count <= '0;
					if (steps_left == 3'h0) begin
						running <= 1'b0;
						switch_enable <= 1'b1;
					end else begin
						steps_left <= steps_left - 3'h1;
					end
				end else begin
					cycle_count <= cycle_count + CW'(1);
				end
			end
		end
	end

	// ==========================================================
	// Checks
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			waited <= 32'h0;
		end else if (request && !switch_enable) begin
			waited <= waited + 32'h1;
		end else begin
			waited <= 32'h0;
		end
	end

	// Delay selection in force when the count started
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			delay_taken <= 3'h0;
		end else if (request && !request_d) begin
			delay_taken <= delay_sel;
		end
	end

	property p_delay_length;
		@(posedge clk) disable iff (!resetn)
		$rose(switch_enable) |->
			waited == 32'((32'(delay_taken) + 32'h1) * STEP_CYCLES) + 32'h1;
	endproperty
	a_delay_length: assert property (p_delay_length)
		else $error("switch enable delay length wrong");

	property p_delay_not_early;
		@(posedge clk) disable iff (!resetn)
		(request && !request_d) |=> !switch_enable;
	endproperty
	a_delay_not_early: assert property (p_delay_not_early)
		else $error("switch enable came without delay");
endmodule // switch_on_timer

// ---- verilog/hub_string_feature_regs.sv ----
module hub_string_feature_regs #(
	parameter int STEP_CYCLES = hub_cfg_pkg::DELAY_STEP_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic CFG_WR,
	input wire logic [7:0] CFG_ADDR,
	input wire logic [7:0] CFG_WDATA,
	output logic [7:0] CFG_RDATA,
	input wire logic I2C_MODE,
	input wire logic SMBUS_MODE,
	input wire logic DESC_REQ,
	input wire logic [7:0] DESC_INDEX,
	input wire logic [5:0] DESC_OFFSET,
	input wire logic [6:0] MAKER_TEXT_LENGTH,
	input wire logic [6:0] ITEM_TEXT_LENGTH,
	output logic DESC_ACK,
	output logic DESC_VALID,
	output logic [7:0] DESC_DATA,
	input wire logic HS_LINK_UP,
	input wire logic HS_SUSPENDED,
	input wire logic SS_LINK_UP,
	input wire logic SS_SUSPENDED,
	output logic HS_LINK_UP_OUT,
	output logic HS_SUSPENDED_OUT,
	output logic SS_LINK_UP_OUT,
	output logic SS_SUSPENDED_OUT,
	output logic PLL_SPREAD_OFF,
	input wire logic POWER_ON_REQUEST,
	output logic PORT_POWER_SWITCH_CTL,
	output logic CONFIG_IN_PROGRESS,
	output logic UPSTREAM_CONNECT_ALLOW
);
	import hub_cfg_pkg::*;

	logic [7:0] text [TEXT_TOTAL];
	logic [7:0] feature;
	logic host_config_reset;
	logic config_in_progress;
	logic i2c_mode_d;
	logic smbus_mode_d;
	logic soft_clear;
	logic text_hit;
	logic [6:0] text_index;
	logic feature_wr;
	logic status_wr;
	logic mode_enter;
	logic flag_clear;
	logic maker_sel;
	logic item_sel;
	logic [6:0] desc_addr;
	logic [7:0] next_rdata;

	assign soft_clear = host_config_reset;
	assign text_hit = CFG_ADDR >= MAKER_TEXT_BASE && CFG_ADDR <= TEXT_END;
	assign text_index = 7'(CFG_ADDR - MAKER_TEXT_BASE);
	assign feature_wr = CFG_WR && CFG_ADDR == FEATURE_CFG_ADDR;
	assign status_wr = CFG_WR && CFG_ADDR == HOST_STATUS_ADDR;

	// ==========================================================
	// Text byte storage
	generate
		for (genvar i = 0; i < TEXT_TOTAL; i++) begin : g_text
			always_ff @(posedge REF_CLK or negedge RESETN) begin
				if (!RESETN) begin
					text[i] <= REG_RESET;
				end else if (soft_clear) begin
					text[i] <= REG_RESET;
				end else if (CFG_WR && text_hit && text_index == 7'(i)) begin
					text[i] <= CFG_WDATA;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Feature register, loader or host writes
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			feature <= REG_RESET;
		end else if (soft_clear) begin
			feature <= REG_RESET;
		end else if (feature_wr) begin
			feature <= CFG_WDATA;
		end
	end

	assign PLL_SPREAD_OFF = feature[SPREAD_OFF_BIT];

	// ==========================================================
	// Status and command register
	assign mode_enter = (I2C_MODE && !i2c_mode_d) ||
		(SMBUS_MODE && !smbus_mode_d);
	assign flag_clear = (!I2C_MODE && i2c_mode_d) ||
		(status_wr && SMBUS_MODE && CFG_WDATA[CFG_ACTIVE_BIT]);

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			i2c_mode_d <= 1'b0;
			smbus_mode_d <= 1'b0;
		end else begin
			i2c_mode_d <= I2C_MODE;
			smbus_mode_d <= SMBUS_MODE;
		end
	end

	// Setting wins over a clear in the same cycle
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			config_in_progress <= 1'b0;
		end else if (mode_enter || soft_clear) begin
			config_in_progress <= 1'b1;
		end else if (flag_clear) begin
			config_in_progress <= 1'b0;
		end
	end

	// Reset request accepted only in host mode; writing zero does nothing
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			host_config_reset <= 1'b0;
		end else if (host_config_reset) begin
			host_config_reset <= 1'b0;
		end else if (status_wr && SMBUS_MODE &&
			CFG_WDATA[HOST_RESET_BIT]) begin
			host_config_reset <= 1'b1;
		end
	end

	assign CONFIG_IN_PROGRESS = config_in_progress;
	assign UPSTREAM_CONNECT_ALLOW = !config_in_progress;

	// ==========================================================
	// Register read port, one cycle latency
	always_comb begin
		next_rdata = REG_RESET;
		if (text_hit) begin
			next_rdata = text[text_index];
		end else if (CFG_ADDR == FEATURE_CFG_ADDR) begin
			next_rdata = feature;
		end else if (CFG_ADDR == HOST_STATUS_ADDR) begin
			next_rdata = {6'h00, host_config_reset, config_in_progress};
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			CFG_RDATA <= REG_RESET;
		end else begin
			CFG_RDATA <= next_rdata;
		end
	end

	// ==========================================================
	// String descriptor byte fetch
	assign maker_sel = DESC_INDEX == DESC_INDEX_MAKER &&
		MAKER_TEXT_LENGTH != 7'h00;
	assign item_sel = DESC_INDEX == DESC_INDEX_ITEM &&
		ITEM_TEXT_LENGTH != 7'h00;
	assign desc_addr = item_sel ? {1'b1, DESC_OFFSET} : {1'b0, DESC_OFFSET};

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			DESC_ACK <= 1'b0;
			DESC_VALID <= 1'b0;
			DESC_DATA <= REG_RESET;
		end else begin
			DESC_ACK <= DESC_REQ;
			DESC_VALID <= DESC_REQ && (
				(maker_sel && {1'b0, DESC_OFFSET} < MAKER_TEXT_LENGTH) ||
				(item_sel && {1'b0, DESC_OFFSET} < ITEM_TEXT_LENGTH));
			DESC_DATA <= (DESC_REQ && (maker_sel || item_sel)) ?
				text[desc_addr] : REG_RESET;
		end
	end

	// ==========================================================
	// Gated status outputs
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			HS_LINK_UP_OUT <= 1'b0;
			HS_SUSPENDED_OUT <= 1'b0;
			SS_LINK_UP_OUT <= 1'b0;
			SS_SUSPENDED_OUT <= 1'b0;
		end else begin
			HS_LINK_UP_OUT <= feature[LINK_PINS_EN_BIT] && HS_LINK_UP;
			HS_SUSPENDED_OUT <= feature[LINK_PINS_EN_BIT] && HS_SUSPENDED;
			SS_LINK_UP_OUT <= feature[LINK_PINS_EN_BIT] && SS_LINK_UP;
			SS_SUSPENDED_OUT <= feature[LINK_PINS_EN_BIT] && SS_SUSPENDED;
		end
	end

	// ==========================================================
	// Power switch delay
	switch_on_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_switch_on_timer (
		.clk(REF_CLK),
		.resetn(RESETN),
		.request(POWER_ON_REQUEST),
		.delay_sel(feature[DELAY_SEL_MSB:DELAY_SEL_LSB]),
		.switch_enable(PORT_POWER_SWITCH_CTL)
	);

	// ==========================================================
	// Checks
	property p_maker_byte;
		@(posedge REF_CLK) disable iff (!RESETN)
		(DESC_REQ && maker_sel && !CFG_WR && !soft_clear &&
			{1'b0, DESC_OFFSET} < MAKER_TEXT_LENGTH) |=>
			DESC_VALID && DESC_DATA == text[{1'b0, $past(DESC_OFFSET)}];
	endproperty
	a_maker_byte: assert property (p_maker_byte)
		else $error("maker byte not returned");

	property p_maker_len;
		@(posedge REF_CLK) disable iff (!RESETN)
		(DESC_REQ && DESC_INDEX == DESC_INDEX_MAKER &&
			{1'b0, DESC_OFFSET} >= MAKER_TEXT_LENGTH) |=> !DESC_VALID;
	endproperty
	a_maker_len: assert property (p_maker_len)
		else $error("maker byte beyond length");

	property p_item_byte;
		@(posedge REF_CLK) disable iff (!RESETN)
		(DESC_REQ && item_sel && !CFG_WR && !soft_clear &&
			{1'b0, DESC_OFFSET} < ITEM_TEXT_LENGTH) |=>
			DESC_VALID && DESC_DATA == text[{1'b1, $past(DESC_OFFSET)}];
	endproperty
	a_item_byte: assert property (p_item_byte)
		else $error("item byte not returned");

	property p_item_len;
		@(posedge REF_CLK) disable iff (!RESETN)
		(DESC_REQ && DESC_INDEX == DESC_INDEX_ITEM &&
			{1'b0, DESC_OFFSET} >= ITEM_TEXT_LENGTH) |=> !DESC_VALID;
	endproperty
	a_item_len: assert property (p_item_len)
		else $error("item byte beyond length");

	property p_status_gate;
		@(posedge REF_CLK) disable iff (!RESETN)
		!feature[LINK_PINS_EN_BIT] |=> !HS_LINK_UP_OUT && !HS_SUSPENDED_OUT
			&& !SS_LINK_UP_OUT && !SS_SUSPENDED_OUT;
	endproperty
	a_status_gate: assert property (p_status_gate)
		else $error("status output active while disabled");

	property p_status_pass;
		@(posedge REF_CLK) disable iff (!RESETN)
		feature[LINK_PINS_EN_BIT] |=> HS_LINK_UP_OUT == $past(HS_LINK_UP)
			&& HS_SUSPENDED_OUT == $past(HS_SUSPENDED)
			&& SS_LINK_UP_OUT == $past(SS_LINK_UP)
			&& SS_SUSPENDED_OUT == $past(SS_SUSPENDED);
	endproperty
	a_status_pass: assert property (p_status_pass)
		else $error("status output not following source");

	property p_feature_write;
		@(posedge REF_CLK) disable iff (!RESETN)
		(feature_wr && !soft_clear) |=> feature == $past(CFG_WDATA)
			&& PLL_SPREAD_OFF == $past(CFG_WDATA[SPREAD_OFF_BIT]);
	endproperty
	a_feature_write: assert property (p_feature_write)
		else $error("feature write not taken");

	property p_flag_blocks;
		@(posedge REF_CLK) disable iff (!RESETN)
		$rose(SMBUS_MODE) |=> CONFIG_IN_PROGRESS && !UPSTREAM_CONNECT_ALLOW;
	endproperty
	a_flag_blocks: assert property (p_flag_blocks)
		else $error("config flag not set on mode entry");

	property p_host_reset;
		@(posedge REF_CLK) disable iff (!RESETN)
		(status_wr && SMBUS_MODE && CFG_WDATA[HOST_RESET_BIT] &&
			!host_config_reset) |=> host_config_reset ##1
			(!host_config_reset && config_in_progress && feature == REG_RESET);
	endproperty
	a_host_reset: assert property (p_host_reset)
		else $error("host reset sequence wrong");
endmodule // hub_string_feature_regs

// ---- dv/cfg_host_model.sv ----
module cfg_host_model
	import hub_cfg_pkg::*;
(
	input wire logic clk,
	output logic wr,
	output logic [7:0] addr,
	output logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wr = 1'b0;
		addr = REG_RESET;
		wdata = REG_RESET;
	end
	// ==========================================================
	// Register access
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		wr = 1'b0;
		wdata = ~d;
	endtask
	task automatic point(input logic [7:0] a);
		@(posedge clk);
		#1;
		addr = a;
	endtask
	// Each character stored low byte first
	task automatic load_text(input logic [7:0] base, input string s);
		for (int i = 0; i < s.len(); i++) begin
			write(base + 8'(2 * i), s[i]);
			write(base + 8'(2 * i + 1), 8'h00);
		end
	endtask
	// Bits 7:5 always written as zero
	task automatic feature(input logic [4:0] v);
		write(FEATURE_CFG_ADDR, {3'b000, v});
	endtask
	// Flag released by writing one
	task automatic release_config();
		write(HOST_STATUS_ADDR, 8'h01);
	endtask
endmodule // cfg_host_model

// ---- dv/hub_string_feature_regs_tb.sv ----
module hub_string_feature_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hub_cfg_pkg::*;
	localparam int SIM_STEP = 4;
	logic clk = 1'b0, rstn = 1'b0, wr, i2c = 1'b0, smb = 1'b0;
	logic [7:0] addr, wdata, rdata, d_index = 8'h00, d_data;
	logic [5:0] d_off = 6'h00;
	logic [6:0] mlen = 7'h00, ilen = 7'h00;
	logic d_req = 1'b0, d_ack, d_valid, pwr_req = 1'b0, pwr, spread;
	logic flag, allow;
	logic hs_link_up_out = 1'b0, hs_susp = 1'b0, ss_up = 1'b0, ss_susp = 1'b0;
	logic [3:0] st_out;
	int bad_count = 0, tests_run = 0;
	always #5 clk = ~clk;
	cfg_host_model host_u (.clk(clk), .wr(wr), .addr(addr), .wdata(wdata));
	hub_string_feature_regs #(.STEP_CYCLES(SIM_STEP)) dut_u (
		.REF_CLK(clk), .RESETN(rstn), .CFG_WR(wr), .CFG_ADDR(addr),
		.CFG_WDATA(wdata), .CFG_RDATA(rdata), .I2C_MODE(i2c),
		.SMBUS_MODE(smb), .DESC_REQ(d_req), .DESC_INDEX(d_index),
		.DESC_OFFSET(d_off), .MAKER_TEXT_LENGTH(mlen),
		.ITEM_TEXT_LENGTH(ilen), .DESC_ACK(d_ack), .DESC_VALID(d_valid),
		.DESC_DATA(d_data), .HS_LINK_UP(hs_link_up_out),
		.HS_SUSPENDED(hs_susp), .SS_LINK_UP(ss_up),
		.SS_SUSPENDED(ss_susp), .HS_LINK_UP_OUT(st_out[3]),
		.HS_SUSPENDED_OUT(st_out[2]), .SS_LINK_UP_OUT(st_out[1]),
		.SS_SUSPENDED_OUT(st_out[0]), .PLL_SPREAD_OFF(spread),
		.POWER_ON_REQUEST(pwr_req), .PORT_POWER_SWITCH_CTL(pwr),
		.CONFIG_IN_PROGRESS(flag), .UPSTREAM_CONNECT_ALLOW(allow));
	// ==========================================================
	// Helpers
	task automatic chk(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		host_u.point(a);
		edges(1);
		chk("register read", rdata, exp);
	endtask
	task automatic desc(input logic [7:0] idx, input logic [5:0] off,
			input logic v, input logic [7:0] exp);
		edges(1);
		d_req = 1'b1;
		d_index = idx;
		d_off = off;
		edges(1);
		d_req = 1'b0;
		chk("descriptor ack", {7'h00, d_ack}, 8'h01);
		chk("descriptor valid", {7'h00, d_valid}, {7'h00, v});
		chk("descriptor data", d_data, exp);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("allow after reset", {7'h00, allow}, 8'h01);
		rd(FEATURE_CFG_ADDR, REG_RESET);
		rd(HOST_STATUS_ADDR, REG_RESET);
		rd(MAKER_TEXT_BASE, REG_RESET);
		rd(TEXT_END, REG_RESET);
		rd(8'hE0, 8'h00);
	endtask
	task automatic t_feature();
		host_u.feature(5'h11);
		rd(FEATURE_CFG_ADDR, 8'h11);
		chk("spread off", {7'h00, spread}, 8'h01);
		{hs_link_up_out, hs_susp, ss_up, ss_susp} = 4'hA;
		edges(2);
		chk("status on", {4'h0, st_out}, 8'h0A);
		{hs_link_up_out, hs_susp, ss_up, ss_susp} = 4'h5;
		edges(2);
		chk("status follow", {4'h0, st_out}, 8'h05);
		host_u.feature(5'h01);
		edges(2);
		chk("status gated", {4'h0, st_out}, 8'h00);
		host_u.feature(5'h00);
		chk("spread on", {7'h00, spread}, 8'h00);
	endtask
	task automatic t_text();
		string s = "Hub";
		host_u.load_text(MAKER_TEXT_BASE, s);
		host_u.load_text(ITEM_TEXT_BASE, "X");
		mlen = 7'd6;
		ilen = 7'd2;
		rd(MAKER_TEXT_BASE + 8'h02, 8'h75);
		for (int i = 0; i < 6; i++)
			desc(DESC_INDEX_MAKER, 6'(i), 1'b1,
				i % 2 ? 8'h00 : s[i / 2]);
		desc(DESC_INDEX_MAKER, 6'd6, 1'b0, 8'h00);
		desc(DESC_INDEX_ITEM, 6'd0, 1'b1, 8'h58);
		desc(DESC_INDEX_ITEM, 6'd2, 1'b0, 8'h00);
		desc(8'h01, 6'd0, 1'b0, 8'h00);
		mlen = 7'd0;
		desc(DESC_INDEX_MAKER, 6'd0, 1'b0, 8'h00);
	endtask
	task automatic t_power();
		int n = 0;
		host_u.feature(5'h02);
		pwr_req = 1'b1;
		while (n < 40 && pwr !== 1'b1) begin
			edges(1);
			n++;
		end
		chk("switch delay", 8'(n), 8'(2 * SIM_STEP + 1));
		if (n == 40)
			wrap_up();
		pwr_req = 1'b0;
		edges(1);
		chk("switch drop", {7'h00, pwr}, 8'h00);
	endtask
	task automatic t_flag();
		smb = 1'b1;
		edges(2);
		chk("flag set", {6'h00, flag, allow}, 8'h02);
		host_u.feature(5'h11);
		host_u.write(MAKER_TEXT_BASE, 8'hAA);
		host_u.write(HOST_STATUS_ADDR, 8'h02);
		edges(1);
		rd(FEATURE_CFG_ADDR, 8'h00);
		rd(MAKER_TEXT_BASE, 8'h00);
		rd(HOST_STATUS_ADDR, 8'h01);
		host_u.release_config();
		edges(1);
		chk("flag clear", {6'h00, flag, allow}, 8'h01);
		smb = 1'b0;
		i2c = 1'b1;
		edges(2);
		host_u.write(HOST_STATUS_ADDR, 8'h01);
		edges(1);
		chk("flag held", {6'h00, flag, allow}, 8'h02);
		i2c = 1'b0;
		edges(2);
		chk("flag exit", {6'h00, flag, allow}, 8'h01);
	endtask
	task automatic t_rerun();
		host_u.feature(5'h13);
		host_u.write(ITEM_TEXT_BASE, 8'h5A);
		smb = 1'b1;
		edges(2);
		rstn = 1'b0;
		edges(2);
		smb = 1'b0;
		rstn = 1'b1;
		chk("flag after rerun", {6'h00, flag, allow}, 8'h01);
		chk("spread after rerun", {7'h00, spread}, 8'h00);
		rd(FEATURE_CFG_ADDR, REG_RESET);
		rd(ITEM_TEXT_BASE, REG_RESET);
	endtask
	initial begin
		edges(8);
		rstn = 1'b1;
		t_reset();
		t_feature();
		t_text();
		t_power();
		t_flag();
		t_rerun();
		wrap_up();
	end
endmodule // hub_string_feature_regs_tb
